// ==== design/sdl_map.vh ====
`ifndef SDL_MAP_VH
`define SDL_MAP_VH

// Channel organisation
`define SDL_NUM_CH 6
`define SDL_CODE_W 12
`define SDL_CH_FIRST 3'h0
`define SDL_CH_LAST 3'h5
`define SDL_CODE_MAX 12'hfff

// Register byte offsets
`define SDL_OFF_CTRL 8'h00
`define SDL_OFF_STATUS 8'h04
`define SDL_OFF_STICKY 8'h08
`define SDL_OFF_XCOUNT 8'h0c
`define SDL_OFF_LATCH0 8'h10
`define SDL_OFF_DRIVE0 8'h28
`define SDL_OFF_END 8'h40

// Control fields
`define SDL_CTRL_STANDBY 0
`define SDL_CTRL_CAPEN 1
`define SDL_CTRL_RESET 2'h2

// Sticky fields
`define SDL_STK_DEFER 0
`define SDL_STK_ABORT 1

// AXI responses
`define SDL_RESP_OKAY 2'h0
`define SDL_RESP_SLVERR 2'h2

`endif

// ==== design/sdl_sequencer.v ====
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sdl_map.vh"

module sdl_sequencer #(
   parameter FRAME_W = 73
)(
   input wire aclk, // 125 MHz system clock
   input wire aresetn, // Synchronous reset, low active
   input wire s_axi_awvalid, // Write address valid
   output wire s_axi_awready, // Write address ready
   input wire [7:0] s_axi_awaddr, // Write address
   input wire [2:0] s_axi_awprot, // Unused protection
   input wire s_axi_wvalid, // Write data valid
   output wire s_axi_wready, // Write data ready
   input wire [31:0] s_axi_wdata, // Write data
   input wire [3:0] s_axi_wstrb, // Byte strobes
   output wire s_axi_bvalid, // Write response valid
   input wire s_axi_bready, // Write response ready
   output wire [1:0] s_axi_bresp, // Write response
   input wire s_axi_arvalid, // Read address valid
   output wire s_axi_arready, // Read address ready
   input wire [7:0] s_axi_araddr, // Read address
   input wire [2:0] s_axi_arprot, // Unused protection
   output wire s_axi_rvalid, // Read data valid
   input wire s_axi_rready, // Read data ready
   output wire [31:0] s_axi_rdata, // Read data
   output wire [1:0] s_axi_rresp, // Read response
   input wire pix_clk, // Sampled pixel clock pin
   input wire [11:0] data_bus, // Shared input word bus
   input wire load_sequence_start, // Start strobe
   input wire edge_phase_sel, // High rising, low falling
   input wire load_direction_sel, // Low up, high down
   input wire output_transfer_strobe, // Transfer strobe
   input wire power_down_request, // Standby pin
   input wire output_polarity_invert, // Polarity pin
   output wire [71:0] channel_outputs, // Drive codes, channel 0 in low bits
   output wire output_polarity, // Registered polarity
   output wire frame_valid, // Transferred frame available
   input wire frame_ready, // Frame consumer ready
   output wire [FRAME_W-1:0] frame_data // Polarity bit over six drive codes
);

   reg awready_reg;
   reg wready_reg;
   reg aw_held_reg;
   reg w_held_reg;
   reg [7:0] awaddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;
   reg bvalid_reg;
   reg [1:0] bresp_reg;
   reg arready_reg;
   reg rvalid_reg;
   reg [31:0] rdata_reg;
   reg [1:0] rresp_reg;
   reg [1:0] ctrl_reg;
   reg [1:0] sticky_reg;
   reg [31:0] xcount_reg;
   reg pix_q_reg;
   reg start_armed_reg;
   reg [2:0] ch_idx_reg;
   reg [2:0] remain_reg;
   reg xfr_pend_reg;
   reg xfer_wait_reg;
   reg [71:0] latch_reg;
   reg [71:0] drive_reg;
   reg polarity_reg;
   reg out_valid_reg;
   reg [FRAME_W-1:0] out_data_reg;
   reg skid_valid_reg;
   reg [FRAME_W-1:0] skid_data_reg;

   // Register index decode, shared by read and write
   function [4:0] reg_sel;
      input [7:0] addr;
      begin
         reg_sel = (addr < `SDL_OFF_LATCH0) ? {3'h0, addr[3:2]} : ((addr < `SDL_OFF_END) ? addr[6:2] : 5'h1f);
      end
   endfunction

   function [2:0] step_ch;
      input [2:0] ch;
      input down;
      begin
         step_ch = down ? ch - 3'h1 : ch + 3'h1;
      end
   endfunction

   function [11:0] to_drive;
      input [11:0] code;
      begin
         to_drive = `SDL_CODE_MAX - code;
      end
   endfunction

   wire standby = power_down_request | ctrl_reg[`SDL_CTRL_STANDBY];
   wire pix_rise = pix_clk & ~pix_q_reg;
   wire pix_fall = ~pix_clk & pix_q_reg;
   wire active_edge = edge_phase_sel ? pix_rise : pix_fall;
   wire [2:0] first_ch = load_direction_sel ? `SDL_CH_LAST : `SDL_CH_FIRST;
   wire loading = remain_reg != 3'h0;
   wire xfer_req = (pix_fall & xfr_pend_reg) | xfer_wait_reg;
   wire buf_in_ready = ~skid_valid_reg;
   wire do_xfer = xfer_req & buf_in_ready & ~standby;
   wire pop = out_valid_reg & frame_ready;

   reg [71:0] new_drive;
   integer k;
   always @*
   begin
      new_drive = drive_reg;
      for (k = 0; k < `SDL_NUM_CH; k = k + 1)
         new_drive[k*12 +: 12] = to_drive(latch_reg[k*12 +: 12]);
   end

   // Load sequencing on the selected pixel-clock edge
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pix_q_reg <= 1'b0;
         start_armed_reg <= 1'b0;
         ch_idx_reg <= `SDL_CH_FIRST;
         remain_reg <= 3'h0;
         latch_reg <= 72'h0;
         xfr_pend_reg <= 1'b0;
      end
      else
      begin
         pix_q_reg <= pix_clk;
         if (standby)
         begin
            start_armed_reg <= 1'b0;
            remain_reg <= 3'h0;
            latch_reg <= 72'h0;
            xfr_pend_reg <= 1'b0;
         end
         else
         begin
            if (pix_rise)
               xfr_pend_reg <= output_transfer_strobe;
            else if (pix_fall)
               xfr_pend_reg <= 1'b0;
            if (active_edge)
            begin
               start_armed_reg <= load_sequence_start & ctrl_reg[`SDL_CTRL_CAPEN];
               if (start_armed_reg)
               begin
                  latch_reg[first_ch*12 +: 12] <= data_bus;
                  ch_idx_reg <= step_ch(first_ch, load_direction_sel);
                  remain_reg <= 3'h5;
               end
               else if (loading)
               begin
                  latch_reg[ch_idx_reg*12 +: 12] <= data_bus;
                  ch_idx_reg <= step_ch(ch_idx_reg, load_direction_sel);
                  remain_reg <= remain_reg - 3'h1;
               end
            end
         end
      end
   end

   // Output transfer and polarity
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         drive_reg <= 72'h0;
         polarity_reg <= 1'b0;
         xfer_wait_reg <= 1'b0;
         xcount_reg <= 32'h0;
      end
      else if (standby)
      begin
         drive_reg <= 72'h0;
         xfer_wait_reg <= 1'b0;
         polarity_reg <= output_polarity_invert;
      end
      else
      begin
         polarity_reg <= output_polarity_invert;
         xfer_wait_reg <= xfer_req & ~buf_in_ready; // Deferred while the frame buffer is full
         if (do_xfer)
         begin
            drive_reg <= new_drive;
            xcount_reg <= xcount_reg + 32'h1;
         end
      end
   end

   // Two-entry frame buffer toward the consumer
   always @(posedge aclk)
   begin
      if (!aresetn || standby)
      begin
         out_valid_reg <= 1'b0;
         skid_valid_reg <= 1'b0;
         out_data_reg <= {FRAME_W{1'b0}};
         skid_data_reg <= {FRAME_W{1'b0}};
      end
      else if (pop)
      begin
         if (skid_valid_reg)
         begin
            out_data_reg <= skid_data_reg;
            skid_valid_reg <= 1'b0;
         end
         else
         begin
            out_valid_reg <= do_xfer;
            out_data_reg <= {output_polarity_invert, new_drive};
         end
      end
      else if (do_xfer)
      begin
         if (!out_valid_reg)
         begin
            out_valid_reg <= 1'b1;
            out_data_reg <= {output_polarity_invert, new_drive};
         end
         else
         begin
            skid_valid_reg <= 1'b1;
            skid_data_reg <= {output_polarity_invert, new_drive};
         end
      end
   end

   // AXI write path
   wire aw_take = s_axi_awvalid & awready_reg;
   wire w_take = s_axi_wvalid & wready_reg;
   wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
   wire aw_held_next = do_write ? 1'b0 : (aw_held_reg | aw_take);
   wire w_held_next = do_write ? 1'b0 : (w_held_reg | w_take);
   wire [4:0] wsel = reg_sel(awaddr_reg);
   wire ev_defer = xfer_req & ~buf_in_ready;
   wire ev_abort = active_edge & start_armed_reg & loading & ~standby;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h0;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `SDL_RESP_OKAY;
         ctrl_reg <= `SDL_CTRL_RESET;
         sticky_reg <= 2'h0;
      end
      else
      begin
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         awready_reg <= ~aw_held_next;
         wready_reg <= ~w_held_next;
         if (aw_take)
            awaddr_reg <= s_axi_awaddr;
         if (w_take)
         begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (bvalid_reg && s_axi_bready)
            bvalid_reg <= 1'b0;
         else if (do_write)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wsel == 5'h1f) ? `SDL_RESP_SLVERR : `SDL_RESP_OKAY;
         end
         if (do_write && wsel == reg_sel(`SDL_OFF_CTRL) && wstrb_reg[0])
            ctrl_reg <= wdata_reg[1:0];
         if (do_write && wsel == reg_sel(`SDL_OFF_STICKY) && wstrb_reg[0]) // W1c, event wins
            sticky_reg <= (sticky_reg & ~wdata_reg[1:0]) | {ev_abort, ev_defer};
         else
            sticky_reg <= sticky_reg | {ev_abort, ev_defer};
      end
   end

   // AXI read path
   wire [4:0] rsel = reg_sel(s_axi_araddr);
   wire [2:0] rch = rsel[2:0] - 3'h4;
   wire [2:0] rdch = rsel[2:0] - 3'h2;
   reg [31:0] rmux;
   reg rerr;
   always @*
   begin
      rmux = 32'h0;
      rerr = 1'b0;
      if (rsel == 5'h00)
         rmux = {30'h0, ctrl_reg};
      else if (rsel == 5'h01)
         rmux = {24'h0, out_valid_reg, xfer_wait_reg, standby, start_armed_reg, ch_idx_reg, loading};
      else if (rsel == 5'h02)
         rmux = {30'h0, sticky_reg};
      else if (rsel == 5'h03)
         rmux = xcount_reg;
      else if (rsel >= 5'h04 && rsel < 5'h0a)
         rmux = {20'h0, latch_reg[rch*12 +: 12]};
      else if (rsel >= 5'h0a && rsel < 5'h10)
         rmux = {20'h0, drive_reg[rdch*12 +: 12]};
      else
         rerr = 1'b1;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= `SDL_RESP_OKAY;
      end
      else if (rvalid_reg)
      begin
         if (s_axi_rready)
         begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
      else if (s_axi_arvalid && arready_reg)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= rmux;
         rresp_reg <= rerr ? `SDL_RESP_SLVERR : `SDL_RESP_OKAY;
      end
      else
         arready_reg <= 1'b1;
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign channel_outputs = drive_reg;
   assign output_polarity = polarity_reg;
   assign frame_valid = out_valid_reg;
   assign frame_data = out_data_reg;

endmodule
`default_nettype wire

// ==== dv/sdl_pix_src.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdl_pix_src (
   input wire logic aclk, // System clock
   input wire logic edge_phase_sel, // Active edge level
   output logic pix_clk, // Pixel clock
   output logic [11:0] data_bus, // One bus and clock per device
   output logic load_sequence_start, // Start strobe
   output logic output_transfer_strobe // Transfer strobe
);
   initial
   begin
      pix_clk = 1'b0;
      data_bus = 12'h0;
      load_sequence_start = 1'b0;
      output_transfer_strobe = 1'b0;
   end
   task automatic half(input logic v);
      pix_clk <= v;
      repeat (4) @(posedge aclk);
   endtask
   // Word k of w goes out k-th
   task automatic load(input logic [71:0] w);
      load_sequence_start <= 1'b1;
      half(~edge_phase_sel);
      half(edge_phase_sel);
      load_sequence_start <= 1'b0;
      for (int k = 0; k < 6; k++)
      begin
         data_bus <= w[12*k+:12];
         half(~edge_phase_sel);
         half(edge_phase_sel);
      end
      data_bus <= ~w[71:60];
   endtask
   task automatic xfer();
      output_transfer_strobe <= 1'b1;
      half(1'b0);
      half(1'b1);
      output_transfer_strobe <= 1'b0;
      half(1'b0);
   endtask
endmodule
`default_nettype wire

// ==== dv/sdl_seq_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdl_seq_chk #(
   parameter FRAME_W = 73
)(
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset
   input wire logic s_axi_awvalid, // Aw valid
   input wire logic s_axi_awready, // Aw ready
   input wire logic s_axi_bvalid, // B valid
   input wire logic s_axi_bready, // B ready
   input wire logic [1:0] s_axi_bresp, // B resp
   input wire logic s_axi_arvalid, // Ar valid
   input wire logic s_axi_arready, // Ar ready
   input wire logic [7:0] s_axi_araddr, // Ar addr
   input wire logic s_axi_rvalid, // R valid
   input wire logic s_axi_rready, // R ready
   input wire logic [31:0] s_axi_rdata, // R data
   input wire logic [1:0] s_axi_rresp, // R resp
   input wire logic power_down_request, // Standby
   input wire logic output_polarity_invert, // Invert pin
   input wire logic output_polarity, // Polarity
   input wire logic [71:0] channel_outputs, // Drives
   input wire logic frame_valid, // Frame valid
   input wire logic frame_ready, // Frame ready
   input wire logic [FRAME_W-1:0] frame_data // Frame
);
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   aw_take_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("awready high after take");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read answer");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h40
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
   standby_clear_a: assert property (power_down_request [*4] |-> channel_outputs == 72'h0 && !frame_valid)
      else $error("standby kept data");
   frame_hold_a: assert property (frame_valid && !frame_ready |=> frame_valid && $stable(frame_data))
      else $error("frame dropped");
   pol_follow_a: assert property ($past(aresetn) |-> output_polarity == $past(output_polarity_invert))
      else $error("polarity wrong");
   cover property (frame_valid && frame_ready);
   cover property (power_down_request [*4]);
   cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind sdl_sequencer sdl_seq_chk #(.FRAME_W(FRAME_W)) chk (.*);
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic pix_clk, load_sequence_start, output_transfer_strobe, edge_phase_sel, load_direction_sel;
   logic power_down_request, output_polarity_invert, output_polarity, frame_valid, frame_ready;
   logic [11:0] data_bus;
   logic [71:0] channel_outputs;
   logic [72:0] frame_data, last;
   int error_cnt, checked, cyc;
   sdl_sequencer uut (.*);
   sdl_pix_src src (.*);
   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task automatic cmp(input logic [72:0] g, e);
      checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic results();
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         results();
      end
   end
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
         @(posedge aclk);
      while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do
         @(posedge aclk);
      while (!s_axi_rvalid);
      cmp({s_axi_rresp, s_axi_rdata}, {r, d});
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         #1;
      end
      while (s_axi_awvalid || s_axi_wvalid);
      do
         @(posedge aclk);
      while (!s_axi_bvalid);
      cmp(s_axi_bresp, r);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic pop(input logic [72:0] e);
      frame_ready <= 1'b1;
      do
         @(posedge aclk);
      while (!frame_valid);
      cmp(frame_data, e);
      frame_ready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic run(input int i);
      logic [71:0] w, e;
      edge_phase_sel <= ~i[0];
      load_direction_sel <= i[1];
      output_polarity_invert <= i[0];
      for (int k = 0; k < 6; k++)
         w[12*k+:12] = 12'hfff - 12'h2c3 * k - i;
      for (int k = 0; k < 6; k++)
         e[12*k+:12] = 12'hfff - w[12*(i[1] ? 5 - k : k)+:12];
      @(posedge aclk);
      src.load(w);
      for (int k = 0; k < 6; k++)
         rd(8'h10 + 4 * (i[1] ? 5 - k : k), w[12*k+:12], 2'h0);
      src.xfer();
      last = {i[0], e};
      cmp({output_polarity, channel_outputs}, last);
      for (int k = 0; k < 6; k++)
         rd(8'h28 + 4 * k, e[12*k+:12], 2'h0);
      pop(last);
   endtask
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = 0;
      s_axi_wstrb = 4'hf;
      {edge_phase_sel, load_direction_sel, power_down_request, output_polarity_invert, frame_ready} = 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(8'h00, 32'h2, 2'h0);
      rd(8'h40, 32'h0, 2'h2);
      wr(8'h40, 32'h0, 2'h2);
      wr(8'h00, 32'h2, 2'h0);
      for (int i = 0; i < 4; i++)
         run(i);
      // Third transfer waits for buffer space
      repeat (3) src.xfer();
      repeat (3) pop(last);
      rd(8'h08, 32'h1, 2'h0);
      wr(8'h08, 32'h1, 2'h0);
      rd(8'h08, 32'h0, 2'h0);
      power_down_request <= 1'b1;
      repeat (6) @(posedge aclk);
      cmp({frame_valid, channel_outputs}, 73'h0);
      rd(8'h10, 32'h0, 2'h0);
      power_down_request <= 1'b0;
      @(posedge aclk);
      run(4);
      rd(8'h0c, 32'h8, 2'h0);
      // Start ignored while capture is disabled
      wr(8'h00, 32'h0, 2'h0);
      src.load(72'h0);
      rd(8'h10, 32'hffb, 2'h0);
      // Soft standby clears the drive codes
      wr(8'h00, 32'h1, 2'h0);
      rd(8'h28, 32'h0, 2'h0);
      results();
   end
endmodule
`default_nettype wire
